/* File: shared/nicim_cfg.svh */
`ifndef NICIM_CFG_SVH
`define NICIM_CFG_SVH

`define NICIM_ADDR_W 8
`define NICIM_OFS_MASK 8'h38
`define NICIM_OFS_STAT 8'h40

`define NICIM_MASK_RESET 32'h00000000
`define NICIM_MASK_WMASK 32'h0001a3ef
`define NICIM_NORMAL_BITS 32'h00000045
`define NICIM_ABNORM_BITS 32'h000023aa
`define NICIM_NORMAL_EN_BIT 16
`define NICIM_ABNORM_EN_BIT 15

`define NICIM_ST_TX_DONE 0
`define NICIM_ST_TX_STOP 1
`define NICIM_ST_TX_NOBUF 2
`define NICIM_ST_TX_JABBER 3
`define NICIM_ST_TX_UNDER 5
`define NICIM_ST_RX_DONE 6
`define NICIM_ST_RX_NOBUF 7
`define NICIM_ST_RX_STOP 8
`define NICIM_ST_RX_WDOG 9
`define NICIM_ST_BUS_ERR 13
`define NICIM_ST_BERR_MSB 24
`define NICIM_ST_BERR_LSB 23

`define NICIM_PURGE_W 8
`define NICIM_PURGE_LSB 17
`define NICIM_PURGE_MSB 24
`define NICIM_PURGE_OVF_BIT 31
`define NICIM_MISS_W 7
`define NICIM_MISS_LSB 0
`define NICIM_MISS_MSB 6
`define NICIM_MISS_OVF_BIT 16
`define NICIM_PURGE_MAX 8'hff
`define NICIM_MISS_MAX 7'h7f

`endif

/* File: shared/nicim_pkg.sv */
package nicim_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } nicim_bus_req_t;

   typedef struct packed {
      logic purge;
      logic missed;
   } nicim_loss_evt_t;

   typedef enum logic [1:0] {
      NICIM_RX_RUN = 2'b01,
      NICIM_RX_SUSP = 2'b10
   } nicim_rx_state_t;

endpackage : nicim_pkg

/* File: core/nicim_sat_counter.sv */
`include "nicim_cfg.svh"

// Event counter with sticky overflow; holds at its top value once wrapped would occur.
module nicim_sat_counter #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic event_in,
   input wire logic clear,
   output logic [W-1:0] count,
   output logic ovf
);

   logic at_max;

   assign at_max = &count;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= '0;
      end else if (clear) begin
         // An event in the clearing cycle is counted after the clear
         count <= event_in ? W'(1) : '0;
      end else if (event_in && !at_max) begin
         count <= W'(count + W'(1));
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ovf <= 1'b0;
      end else if (event_in && at_max && !clear) begin
         ovf <= 1'b1;
      end else if (clear) begin
         ovf <= 1'b0;
      end
   end

endmodule : nicim_sat_counter

/* File: core/nicim_top.sv */
`include "nicim_cfg.svh"

module nicim_top
   import nicim_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire nicim_bus_req_t bus_req,
   output logic [31:0] rd_data,
   input wire logic [31:0] event_status,
   input wire nicim_loss_evt_t loss_evt,
   input wire logic rx_fetch_host_owned,
   input wire logic rx_restart,
   output logic irq,
   output logic normal_irq,
   output logic abnormal_irq,
   output logic [1:0] bus_err_type,
   output logic rx_nobuf_set,
   output logic rx_suspended
);

   logic [31:0] irq_mask;
   logic [31:0] irq_cause;
   logic [31:0] stat_word;
   logic stat_rd;
   logic mask_wr;
   logic [`NICIM_PURGE_W-1:0] purge_count;
   logic [`NICIM_MISS_W-1:0] missed_count;
   logic purge_ovf;
   logic missed_ovf;
   nicim_rx_state_t rx_state;
   nicim_rx_state_t next_rx_state;

   // Per-source gating: a status bit counts only with its own enable and its class enable
   function automatic logic [31:0] gate_events(input logic [31:0] mask, input logic [31:0] status);
      logic [31:0] norm_en;
      logic [31:0] abn_en;
      norm_en = mask[`NICIM_NORMAL_EN_BIT] ? `NICIM_NORMAL_BITS : 32'h00000000;
      abn_en = mask[`NICIM_ABNORM_EN_BIT] ? `NICIM_ABNORM_BITS : 32'h00000000;
      return status & mask & (norm_en | abn_en);
   endfunction : gate_events

   assign mask_wr = bus_req.wr && (bus_req.addr == `NICIM_OFS_MASK);
   assign stat_rd = bus_req.rd && (bus_req.addr == `NICIM_OFS_STAT);

   // Interrupt mask register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask <= `NICIM_MASK_RESET;
      end else if (mask_wr) begin
         irq_mask <= bus_req.wdata & `NICIM_MASK_WMASK;
      end
   end

   // Interrupt generation
   assign irq_cause = gate_events(irq_mask, event_status);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
         normal_irq <= 1'b0;
         abnormal_irq <= 1'b0;
      end else begin
         irq <= |irq_cause;
         normal_irq <= |(irq_cause & `NICIM_NORMAL_BITS);
         abnormal_irq <= |(irq_cause & `NICIM_ABNORM_BITS);
      end
   end

   // Error type is captured only while the bus error source is live, so it stays valid after it drops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bus_err_type <= 2'h0;
      end else if (irq_cause[`NICIM_ST_BUS_ERR]) begin
         bus_err_type <= event_status[`NICIM_ST_BERR_MSB:`NICIM_ST_BERR_LSB];
      end
   end

   // Receive descriptor ownership tracking
   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         NICIM_RX_RUN: begin
            if (rx_fetch_host_owned) begin
               next_rx_state = NICIM_RX_SUSP;
            end
         end
         NICIM_RX_SUSP: begin
            if (rx_restart) begin
               next_rx_state = NICIM_RX_RUN;
            end
         end
         default: begin
            next_rx_state = NICIM_RX_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_state <= NICIM_RX_RUN;
      end else begin
         rx_state <= next_rx_state;
      end
   end

   // One pulse per entry into suspension; repeated fetches while suspended do not re-raise it
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_nobuf_set <= 1'b0;
      end else begin
         rx_nobuf_set <= (rx_state == NICIM_RX_RUN) && rx_fetch_host_owned;
      end
   end

   assign rx_suspended = (rx_state == NICIM_RX_SUSP);

   // Loss statistics
   nicim_sat_counter #(
      .W(`NICIM_PURGE_W)
   ) u_purge_cnt (
      .mclk(mclk),
      .rst_b(rst_b),
      .event_in(loss_evt.purge),
      .clear(stat_rd),
      .count(purge_count),
      .ovf(purge_ovf)
   );

   nicim_sat_counter #(
      .W(`NICIM_MISS_W)
   ) u_miss_cnt (
      .mclk(mclk),
      .rst_b(rst_b),
      .event_in(loss_evt.missed),
      .clear(stat_rd),
      .count(missed_count),
      .ovf(missed_ovf)
   );

   always_comb begin
      stat_word = 32'h00000000;
      stat_word[`NICIM_PURGE_OVF_BIT] = purge_ovf;
      stat_word[`NICIM_PURGE_MSB:`NICIM_PURGE_LSB] = purge_count;
      stat_word[`NICIM_MISS_OVF_BIT] = missed_ovf;
      stat_word[`NICIM_MISS_MSB:`NICIM_MISS_LSB] = missed_count;
   end

   // Read port; unmapped addresses and idle cycles return zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 32'h00000000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            `NICIM_OFS_MASK: begin
               rd_data <= irq_mask;
            end
            `NICIM_OFS_STAT: begin
               rd_data <= stat_word;
            end
            default: begin
               rd_data <= 32'h00000000;
            end
         endcase
      end else begin
         rd_data <= 32'h00000000;
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   logic normal_summary_enable;
   logic abnormal_summary_enable;
   assign normal_summary_enable = irq_mask[`NICIM_NORMAL_EN_BIT];
   assign abnormal_summary_enable = irq_mask[`NICIM_ABNORM_EN_BIT];

   a_tx_done_irq: assert property (
      (event_status[`NICIM_ST_TX_DONE] && irq_mask[`NICIM_ST_TX_DONE] && normal_summary_enable)
      |=> (irq && normal_irq)
   ) else $error("transmit done did not raise interrupt");

   a_tx_nobuf_irq: assert property (
      (event_status[`NICIM_ST_TX_NOBUF] && irq_mask[`NICIM_ST_TX_NOBUF] && normal_summary_enable)
      |=> (irq && normal_irq)
   ) else $error("transmit no-buffer did not raise interrupt");

   a_rx_done_irq: assert property (
      (event_status[`NICIM_ST_RX_DONE] && irq_mask[`NICIM_ST_RX_DONE] && normal_summary_enable)
      |=> (irq && normal_irq)
   ) else $error("receive done did not raise interrupt");

   a_tx_stop_irq: assert property (
      (event_status[`NICIM_ST_TX_STOP] && irq_mask[`NICIM_ST_TX_STOP] && abnormal_summary_enable)
      |=> (irq && abnormal_irq)
   ) else $error("transmit stopped did not raise interrupt");

   a_jabber_irq: assert property (
      (event_status[`NICIM_ST_TX_JABBER] && irq_mask[`NICIM_ST_TX_JABBER] && abnormal_summary_enable)
      |=> (irq && abnormal_irq)
   ) else $error("jabber did not raise interrupt");

   a_underrun_irq: assert property (
      (event_status[`NICIM_ST_TX_UNDER] && irq_mask[`NICIM_ST_TX_UNDER] && abnormal_summary_enable)
      |=> (irq && abnormal_irq)
   ) else $error("underrun did not raise interrupt");

   a_rx_nobuf_irq: assert property (
      (event_status[`NICIM_ST_RX_NOBUF] && irq_mask[`NICIM_ST_RX_NOBUF] && abnormal_summary_enable)
      |=> (irq && abnormal_irq)
   ) else $error("receive no-buffer did not raise interrupt");

   a_rx_stop_irq: assert property (
      (event_status[`NICIM_ST_RX_STOP] && irq_mask[`NICIM_ST_RX_STOP] && abnormal_summary_enable)
      |=> (irq && abnormal_irq)
   ) else $error("receive stopped did not raise interrupt");

   a_wdog_irq: assert property (
      (event_status[`NICIM_ST_RX_WDOG] && irq_mask[`NICIM_ST_RX_WDOG] && abnormal_summary_enable)
      |=> (irq && abnormal_irq)
   ) else $error("watchdog did not raise interrupt");

   a_bus_err_irq: assert property (
      (event_status[`NICIM_ST_BUS_ERR] && irq_mask[`NICIM_ST_BUS_ERR] && abnormal_summary_enable)
      |=> (irq && abnormal_irq && bus_err_type == $past(event_status[`NICIM_ST_BERR_MSB:`NICIM_ST_BERR_LSB]))
   ) else $error("bus error interrupt or type wrong");

   a_normal_class_only: assert property (
      (!abnormal_summary_enable && (event_status & `NICIM_ABNORM_BITS) != 32'h00000000) |=> !abnormal_irq
   ) else $error("abnormal source passed with summary enable clear");

   a_normal_gate_off: assert property (
      (!normal_summary_enable && !abnormal_summary_enable) |=> !irq
   ) else $error("interrupt raised with both summary enables clear");

   a_normal_needs_enable: assert property (!normal_summary_enable |=> !normal_irq)
      else $error("normal interrupt raised with normal enable clear");

   a_abnormal_needs_enable: assert property (!abnormal_summary_enable |=> !abnormal_irq)
      else $error("abnormal interrupt raised with abnormal enable clear");

   a_no_source_quiet: assert property (
      ((event_status & irq_mask & (`NICIM_NORMAL_BITS | `NICIM_ABNORM_BITS)) == 32'h00000000) |=> !irq
   ) else $error("interrupt raised with no enabled source");

   a_irq_class_sum: assert property (irq == (normal_irq || abnormal_irq))
      else $error("interrupt output differs from its class summaries");

   a_bus_type_hold: assert property (!irq_cause[`NICIM_ST_BUS_ERR] |=> $stable(bus_err_type))
      else $error("bus error type changed without a live bus error");

   a_mask_readback: assert property (
      (mask_wr ##1 (bus_req.rd && bus_req.addr == `NICIM_OFS_MASK && !bus_req.wr))
      |=> rd_data == ($past(bus_req.wdata, 2) & `NICIM_MASK_WMASK)
   ) else $error("mask readback differs from written value");

   a_reserved_ignore: assert property (mask_wr |=> (irq_mask & ~`NICIM_MASK_WMASK) == 32'h00000000)
      else $error("reserved mask bits took a write");

   a_stat_reserved: assert property ((stat_word & 32'h7e00ff80) == 32'h00000000)
      else $error("reserved statistics bits nonzero");

   a_purge_count_inc: assert property (
      (loss_evt.purge && !stat_rd && purge_count != `NICIM_PURGE_MAX)
      |=> purge_count == `NICIM_PURGE_W'($past(purge_count) + `NICIM_PURGE_W'(1))
   ) else $error("purged packet counter did not step");

   a_purge_ovf_hold: assert property (
      (loss_evt.purge && !stat_rd && purge_count == `NICIM_PURGE_MAX)
      |=> (purge_ovf && purge_count == `NICIM_PURGE_MAX)
   ) else $error("purged counter overflow not flagged or wrapped");

   a_purge_sat_hold: assert property (
      (purge_ovf && !stat_rd) |=> (purge_ovf && purge_count == `NICIM_PURGE_MAX)
   ) else $error("purged counter left its top value before a read");

   a_miss_count_inc: assert property (
      (loss_evt.missed && !stat_rd && missed_count != `NICIM_MISS_MAX)
      |=> missed_count == `NICIM_MISS_W'($past(missed_count) + `NICIM_MISS_W'(1))
   ) else $error("missed frame counter did not step");

   a_miss_ovf_hold: assert property (
      (loss_evt.missed && !stat_rd && missed_count == `NICIM_MISS_MAX)
      |=> (missed_ovf && missed_count == `NICIM_MISS_MAX)
   ) else $error("missed counter overflow not flagged or wrapped");

   a_miss_sat_hold: assert property (
      (missed_ovf && !stat_rd) |=> (missed_ovf && missed_count == `NICIM_MISS_MAX)
   ) else $error("missed counter left its top value before a read");

   a_stat_read_clear: assert property (
      (stat_rd && !loss_evt.purge && !loss_evt.missed)
      |=> (stat_word == 32'h00000000 && rd_data == $past(stat_word))
   ) else $error("statistics read did not return and clear");

   a_read_purge_counts: assert property (
      (stat_rd && loss_evt.purge) |=> (purge_count == 8'h01 && !purge_ovf)
   ) else $error("purged packet in read cycle was not counted");

   a_read_miss_counts: assert property (
      (stat_rd && loss_evt.missed) |=> (missed_count == 7'h01 && !missed_ovf)
   ) else $error("missed frame in read cycle was not counted");

   a_rx_suspend_flag: assert property (
      (rx_state == NICIM_RX_RUN && rx_fetch_host_owned)
      |=> (rx_nobuf_set && rx_suspended) ##1 !rx_nobuf_set
   ) else $error("receive suspension not reported once");

   a_rx_hold_suspend: assert property (
      (rx_suspended && !rx_restart) |=> (rx_suspended && !rx_nobuf_set)
   ) else $error("receive left suspension or reported it again");

   a_reserved_zero: assert property (
      (bus_req.rd && bus_req.addr == `NICIM_OFS_MASK) |=> (rd_data & ~`NICIM_MASK_WMASK) == 32'h00000000
   ) else $error("reserved mask bits read nonzero");

   c_normal_irq: cover property (normal_summary_enable && (irq_cause & `NICIM_NORMAL_BITS) != 32'h00000000 ##1 irq);
   c_abnormal_irq: cover property (abnormal_summary_enable && irq_cause[`NICIM_ST_BUS_ERR] ##1 irq);
   c_purge_ovf: cover property (purge_ovf ##1 stat_rd);
   c_read_with_event: cover property (stat_rd && loss_evt.missed);
   c_rx_suspend: cover property (rx_nobuf_set ##[1:20] rx_restart);

endmodule : nicim_top

/* File: dv/tb.sv */
`include "nicim_cfg.svh"

module tb
   import nicim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   nicim_bus_req_t bus_req = '0;
   logic [31:0] rd_data;
   logic [31:0] event_status = 32'h0;
   nicim_loss_evt_t loss_evt = '0;
   logic rx_fetch_host_owned = 1'b0;
   logic rx_restart = 1'b0;
   logic irq;
   logic normal_irq;
   logic abnormal_irq;
   logic [1:0] bus_err_type;
   logic rx_nobuf_set;
   logic rx_suspended;
   int n_errors = 0;
   int samples_checked = 0;

   nicim_top dut_u (
      .mclk(mclk),
      .rst_b(rst_b),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .event_status(event_status),
      .loss_evt(loss_evt),
      .rx_fetch_host_owned(rx_fetch_host_owned),
      .rx_restart(rx_restart),
      .irq(irq),
      .normal_irq(normal_irq),
      .abnormal_irq(abnormal_irq),
      .bus_err_type(bus_err_type),
      .rx_nobuf_set(rx_nobuf_set),
      .rx_suspended(rx_suspended)
   );

   always #50 mclk = ~mclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 check(rd_data, exp);
   endtask : rd_chk

   task automatic pulse_loss(input logic p, input logic m);
      @(posedge mclk);
      loss_evt <= '{purge: p, missed: m};
      @(posedge mclk);
      loss_evt <= '0;
   endtask : pulse_loss

   task automatic irq_chk(input logic [2:0] exp);
      repeat (2) @(posedge mclk);
      #1 check({29'h0, irq, normal_irq, abnormal_irq}, {29'h0, exp});
   endtask : irq_chk

   int src[10] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 13};

   initial begin
      logic [31:0] own;
      logic [31:0] oth;
      logic [31:0] b;
      logic nrm;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      rd_chk(8'h38, 32'h0);
      rd_chk(8'h40, 32'h0);
      wr_reg(8'h38, 32'hffffffff);
      rd_chk(8'h38, 32'h0001a3ef);
      rd_chk(8'h3c, 32'h0);
      wr_reg(8'h40, 32'hffffffff);
      rd_chk(8'h40, 32'h0);
      // Write then read with no gap: the read must see the new value
      @(posedge mclk);
      bus_req <= '{addr: 8'h38, wdata: 32'hffff5a5a, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req <= '{addr: 8'h38, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 check(rd_data, 32'h0001024a);
      // Each source: own class enables it, the other class does not, nor does every other enable
      for (int i = 0; i < 10; i++) begin
         b = 32'h1 << src[i];
         nrm = (src[i] == 0) || (src[i] == 2) || (src[i] == 6);
         own = nrm ? 32'h00010000 : 32'h00008000;
         oth = nrm ? 32'h00008000 : 32'h00010000;
         @(posedge mclk);
         event_status <= b | 32'h01000000;
         wr_reg(8'h38, b | own);
         irq_chk({1'b1, nrm, ~nrm});
         if (src[i] == 13) begin
            check({30'h0, bus_err_type}, 32'h2);
         end
         wr_reg(8'h38, b | oth);
         irq_chk(3'b000);
         wr_reg(8'h38, 32'h0001a3ef & ~b);
         irq_chk(3'b000);
      end
      @(posedge mclk);
      event_status <= 32'h0;
      wr_reg(8'h38, 32'h0);
      // Counting, clear on read, and an event landing in the read cycle
      repeat (3) pulse_loss(1'b1, 1'b0);
      repeat (5) pulse_loss(1'b0, 1'b1);
      rd_chk(8'h40, 32'h00060005);
      rd_chk(8'h40, 32'h0);
      @(posedge mclk);
      bus_req <= '{addr: 8'h40, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      loss_evt <= '{purge: 1'b1, missed: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      loss_evt <= '0;
      #1 check(rd_data, 32'h0);
      rd_chk(8'h40, 32'h00020001);
      // Fill both counters to their top value, then one more event each
      for (int k = 0; k < 255; k++) begin
         @(posedge mclk);
         loss_evt <= '{purge: 1'b1, missed: (k < 127)};
      end
      @(posedge mclk);
      loss_evt <= '0;
      rd_chk(8'h40, 32'h01fe007f);
      for (int k = 0; k < 255; k++) begin
         @(posedge mclk);
         loss_evt <= '{purge: 1'b1, missed: (k < 128)};
      end
      pulse_loss(1'b1, 1'b0);
      rd_chk(8'h40, 32'h81ff007f);
      rd_chk(8'h40, 32'h0);
      // Host-owned descriptor suspends receive; a second fetch while suspended is ignored
      for (int n = 0; n < 2; n++) begin
         @(posedge mclk);
         rx_fetch_host_owned <= 1'b1;
         @(posedge mclk);
         rx_fetch_host_owned <= 1'b0;
         #1 check({30'h0, rx_nobuf_set, rx_suspended}, {30'h0, (n == 0), 1'b1});
         @(posedge mclk);
         #1 check({30'h0, rx_nobuf_set, rx_suspended}, 32'h1);
      end
      @(posedge mclk);
      rx_restart <= 1'b1;
      @(posedge mclk);
      rx_restart <= 1'b0;
      @(posedge mclk);
      #1 check({31'h0, rx_suspended}, 32'h0);
      // A reset in mid-run drops every enable, count and flag that is live
      wr_reg(8'h38, 32'h00010001);
      pulse_loss(1'b1, 1'b1);
      @(posedge mclk);
      event_status <= 32'h00000001;
      rx_fetch_host_owned <= 1'b1;
      @(posedge mclk);
      rx_fetch_host_owned <= 1'b0;
      #1 check({30'h0, irq, rx_suspended}, 32'h3);
      @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      #1 check({30'h0, irq, rx_suspended}, 32'h0);
      rd_chk(8'h38, 32'h0);
      rd_chk(8'h40, 32'h0);
      irq_chk(3'b000);
      complete_run();
   end

   // The run needs about 730 cycles; allow over twenty-five times that before calling it a hang
   initial begin
      #2000000;
      n_errors++;
      complete_run();
   end
endmodule : tb
